/* core/ccr_pkg.sv */
package ccr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [11:0] ADDR_PORT_CFG  = 12'h000;
  localparam logic [11:0] ADDR_UNUSED_1  = 12'h001;
  localparam logic [11:0] ADDR_RSVD_2    = 12'h002;
  localparam logic [11:0] ADDR_DEV_ID    = 12'h003;
  localparam logic [11:0] ADDR_READBACK  = 12'h004;
  localparam logic [11:0] ADDR_VER_LOW   = 12'h005;
  localparam logic [11:0] ADDR_VER_HIGH  = 12'h006;
  localparam logic [11:0] ADDR_PUMP      = 12'h010;
  localparam logic [11:0] ADDR_REF_LOW   = 12'h011;
  localparam logic [11:0] ADDR_REF_HIGH  = 12'h012;
  localparam logic [11:0] ADDR_PRESC_A   = 12'h013;
  localparam logic [11:0] ADDR_UPDATE    = 12'h232;

  // field positions in the port configuration, update and readback registers
  localparam int CFG_SDO_HI   = 7;
  localparam int CFG_LSB_HI   = 6;
  localparam int CFG_SOFT_HI  = 5;
  localparam int CFG_SOFT_LO  = 2;
  localparam int CFG_LSB_LO   = 1;
  localparam int CFG_SDO_LO   = 0;
  localparam int UPDATE_BIT   = 0;
  localparam int READBACK_BIT = 0;

  // field widths
  localparam int REF_HIGH_W = 6;
  localparam int PRESC_W    = 6;
  localparam int REF_W      = 14;

  // reset values
  localparam logic [7:0] RST_PORT_CFG = 8'h00;
  localparam logic [0:0] RST_READBACK = 1'h0;
  localparam logic [7:0] RST_VER_LOW  = 8'h00;
  localparam logic [7:0] RST_VER_HIGH = 8'h00;
  localparam logic [7:0] RST_PUMP     = 8'h7d;
  localparam logic [7:0] RST_REF_LOW  = 8'h01;
  localparam logic [5:0] RST_REF_HIGH = 6'h00;
  localparam logic [5:0] RST_PRESC_A  = 6'h00;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ccr_req_s;

  typedef struct packed {
    logic [7:0]       pump;
    logic [REF_W-1:0] ref_div;
    logic [PRESC_W-1:0] presc_a;
  } ccr_pll_s;

endpackage

/* core/ccr_dual_reg.sv */
`timescale 1ns/10ps

module ccr_dual_reg
#(
  parameter int               WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET = '0
)
(
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_clear,
  input  wire logic             i_wr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic             i_update,
  output logic      [WIDTH-1:0] o_buffer,
  output logic      [WIDTH-1:0] o_active
);

  logic [WIDTH-1:0] buffer_reg;
  logic [WIDTH-1:0] buffer_next;
  logic [WIDTH-1:0] active_reg;
  logic [WIDTH-1:0] active_next;

  always_comb
  begin
    buffer_next = buffer_reg;
    active_next = active_reg;
    if (i_clear)
    begin
      buffer_next = RESET;
      active_next = RESET;
    end
    else
    begin
      if (i_wr)
        buffer_next = i_wdata;
      if (i_update)
        active_next = buffer_reg;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      buffer_reg <= RESET;
      active_reg <= RESET;
    end
    else
    begin
      buffer_reg <= buffer_next;
      active_reg <= active_next;
    end
  end

  assign o_buffer = buffer_reg;
  assign o_active = active_reg;

  update_copy_a: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (i_update && !i_clear) |=> (active_reg == $past(buffer_reg)))
    else $error("active copy differs from buffer after update");

  active_hold_a: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (!i_update && !i_clear) |=> $stable(active_reg))
    else $error("active value changed without update");

  soft_clear_a: assert property (
    @(posedge i_clock) disable iff (i_rst)
    i_clear |=> (active_reg == RESET && buffer_reg == RESET))
    else $error("soft reset did not restore default");

endmodule // ccr_dual_reg

/* core/ccr_regs.sv */
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - writes to unmapped addresses change nothing
// - unused addresses and bits ignore writes
// - readback bit selects active over buffered values
// - 14-bit reference divider over two registers
// - 6-bit prescaler divider in low bits
// - writes buffered until update strobe copies them, except port configuration, which takes effect directly
module ccr_regs
#(
  parameter logic [7:0] DEVICE_ID = 8'h5a  // arbitrary value
)
(
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire ccr_pkg::ccr_req_s i_req,
  output logic      [7:0]       o_rdata,
  output logic                  o_rvalid,
  output ccr_pkg::ccr_pll_s     o_pll,
  output logic      [15:0]      o_version,
  output logic                  o_sdo_active,
  output logic                  o_lsb_first,
  output logic                  o_soft_reset
);
  import ccr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  logic       update;
  logic       clear;
  logic       wr_readback;
  logic       wr_ver_low;
  logic       wr_ver_high;
  logic       wr_pump;
  logic       wr_ref_low;
  logic       wr_ref_high;
  logic       wr_presc;
  logic       mapped;
  logic       soft_req;

  always_comb
  begin
    mapped = 1'b0;
    unique case (i_req.addr)
      ADDR_PORT_CFG, ADDR_READBACK, ADDR_VER_LOW, ADDR_VER_HIGH,
      ADDR_PUMP, ADDR_REF_LOW, ADDR_REF_HIGH, ADDR_PRESC_A, ADDR_UPDATE:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // only mapped addresses raise a write strobe
  assign wr_readback = i_req.wr && (i_req.addr == ADDR_READBACK);
  assign wr_ver_low  = i_req.wr && (i_req.addr == ADDR_VER_LOW);
  assign wr_ver_high = i_req.wr && (i_req.addr == ADDR_VER_HIGH);
  assign wr_pump     = i_req.wr && (i_req.addr == ADDR_PUMP);
  assign wr_ref_low  = i_req.wr && (i_req.addr == ADDR_REF_LOW);
  assign wr_ref_high = i_req.wr && (i_req.addr == ADDR_REF_HIGH);
  assign wr_presc    = i_req.wr && (i_req.addr == ADDR_PRESC_A);
  assign update      = i_req.wr && (i_req.addr == ADDR_UPDATE) && i_req.wdata[UPDATE_BIT];
  assign soft_req    = i_req.wr && (i_req.addr == ADDR_PORT_CFG)
                       && (i_req.wdata[CFG_SOFT_HI] || i_req.wdata[CFG_SOFT_LO]);

  ////////////////////////////////////////////////////////////////////////////////
  // port configuration and soft reset

  logic sdo_reg;
  logic sdo_next;
  logic lsb_reg;
  logic lsb_next;
  logic soft_reg;
  logic soft_next;

  always_comb
  begin
    sdo_next  = sdo_reg;
    lsb_next  = lsb_reg;
    soft_next = soft_req && !soft_reg;
    if (soft_reg)
    begin
      sdo_next = RST_PORT_CFG[CFG_SDO_LO];
      lsb_next = RST_PORT_CFG[CFG_LSB_LO];
    end
    else if (i_req.wr && (i_req.addr == ADDR_PORT_CFG))
    begin
      sdo_next = i_req.wdata[CFG_SDO_HI] || i_req.wdata[CFG_SDO_LO];
      lsb_next = i_req.wdata[CFG_LSB_HI] || i_req.wdata[CFG_LSB_LO];
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      sdo_reg  <= RST_PORT_CFG[CFG_SDO_LO];
      lsb_reg  <= RST_PORT_CFG[CFG_LSB_LO];
      soft_reg <= 1'b0;
    end
    else
    begin
      sdo_reg  <= sdo_next;
      lsb_reg  <= lsb_next;
      soft_reg <= soft_next;
    end
  end

  assign clear = soft_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // buffered registers

  logic [0:0]          rb_buf, rb_act;
  logic [7:0]          vl_buf, vl_act;
  logic [7:0]          vh_buf, vh_act;
  logic [7:0]          pp_buf, pp_act;
  logic [7:0]          rl_buf, rl_act;
  logic [REF_HIGH_W-1:0] rh_buf, rh_act;
  logic [PRESC_W-1:0]  pa_buf, pa_act;

  ccr_dual_reg #(.WIDTH(1), .RESET(RST_READBACK)) u_readback (
    .i_clock(i_clock), .i_rst(i_rst), .i_clear(clear), .i_wr(wr_readback),
    .i_wdata(i_req.wdata[READBACK_BIT]), .i_update(update), .o_buffer(rb_buf), .o_active(rb_act));
  ccr_dual_reg #(.WIDTH(8), .RESET(RST_VER_LOW)) u_ver_low (
    .i_clock(i_clock), .i_rst(i_rst), .i_clear(clear), .i_wr(wr_ver_low),
    .i_wdata(i_req.wdata), .i_update(update), .o_buffer(vl_buf), .o_active(vl_act));
  ccr_dual_reg #(.WIDTH(8), .RESET(RST_VER_HIGH)) u_ver_high (
    .i_clock(i_clock), .i_rst(i_rst), .i_clear(clear), .i_wr(wr_ver_high),
    .i_wdata(i_req.wdata), .i_update(update), .o_buffer(vh_buf), .o_active(vh_act));
  ccr_dual_reg #(.WIDTH(8), .RESET(RST_PUMP)) u_pump (
    .i_clock(i_clock), .i_rst(i_rst), .i_clear(clear), .i_wr(wr_pump),
    .i_wdata(i_req.wdata), .i_update(update), .o_buffer(pp_buf), .o_active(pp_act));
  ccr_dual_reg #(.WIDTH(8), .RESET(RST_REF_LOW)) u_ref_low (
    .i_clock(i_clock), .i_rst(i_rst), .i_clear(clear), .i_wr(wr_ref_low),
    .i_wdata(i_req.wdata), .i_update(update), .o_buffer(rl_buf), .o_active(rl_act));
  ccr_dual_reg #(.WIDTH(REF_HIGH_W), .RESET(RST_REF_HIGH)) u_ref_high (
    .i_clock(i_clock), .i_rst(i_rst), .i_clear(clear), .i_wr(wr_ref_high),
    .i_wdata(i_req.wdata[REF_HIGH_W-1:0]), .i_update(update), .o_buffer(rh_buf), .o_active(rh_act));
  ccr_dual_reg #(.WIDTH(PRESC_W), .RESET(RST_PRESC_A)) u_presc (
    .i_clock(i_clock), .i_rst(i_rst), .i_clear(clear), .i_wr(wr_presc),
    .i_wdata(i_req.wdata[PRESC_W-1:0]), .i_update(update), .o_buffer(pa_buf), .o_active(pa_act));

  assign o_pll.pump    = pp_act;
  assign o_pll.ref_div = {rh_act, rl_act};
  assign o_pll.presc_a = pa_act;
  assign o_version     = {vh_act, vl_act};
  assign o_sdo_active  = sdo_reg;
  assign o_lsb_first   = lsb_reg;
  assign o_soft_reset  = soft_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic       sel_act;

  // active bank when readback bit set
  assign sel_act = rb_act[0];

  always_comb
  begin
    rvalid_next = i_req.rd;
    rdata_next  = 8'h00;
    unique case (i_req.addr)
      ADDR_PORT_CFG: rdata_next = {sdo_reg, lsb_reg, soft_reg, 2'b00, soft_reg, lsb_reg, sdo_reg};
      ADDR_DEV_ID:   rdata_next = DEVICE_ID;
      ADDR_READBACK: rdata_next = {7'h00, sel_act ? rb_act : rb_buf};
      ADDR_VER_LOW:  rdata_next = sel_act ? vl_act : vl_buf;
      ADDR_VER_HIGH: rdata_next = sel_act ? vh_act : vh_buf;
      ADDR_PUMP:     rdata_next = sel_act ? pp_act : pp_buf;
      ADDR_REF_LOW:  rdata_next = sel_act ? rl_act : rl_buf;
      ADDR_REF_HIGH: rdata_next = {2'b00, sel_act ? rh_act : rh_buf};
      ADDR_PRESC_A:  rdata_next = {2'b00, sel_act ? pa_act : pa_buf};
      default:       rdata_next = 8'h00;
    endcase
    if (!i_req.rd)
      rdata_next = rdata_reg;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign o_rdata  = rdata_reg;
  assign o_rvalid = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic [91:0] state_vec;
  assign state_vec = {sdo_reg, lsb_reg, rb_buf, rb_act, vl_buf, vl_act, vh_buf, vh_act,
                      pp_buf, pp_act, rl_buf, rl_act, rh_buf, rh_act, pa_buf, pa_act};

  unmapped_write_a: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (i_req.wr && !mapped && !soft_reg) |=> $stable(state_vec))
    else $error("unmapped write changed state");

  ref_high_unused_a: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (i_req.rd && i_req.addr == ADDR_REF_HIGH) |=> (o_rdata[7:6] == 2'b00))
    else $error("unused divider bits read nonzero");

  readback_active_a: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (i_req.rd && i_req.addr == ADDR_REF_LOW && rb_act[0]) |=> (o_rdata == $past(o_pll.ref_div[7:0])))
    else $error("readback did not return active value");

  version_high_a: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (i_req.rd && i_req.addr == ADDR_VER_HIGH && rb_act[0]) |=> (o_rdata == $past(o_version[15:8])))
    else $error("version high byte misplaced");

  presc_width_a: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (i_req.rd && i_req.addr == ADDR_PRESC_A) |=> (o_rdata[7:6] == 2'b00))
    else $error("prescaler unused bits read nonzero");

  strobe_self_clear_a: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (i_req.rd && i_req.addr == ADDR_UPDATE) |=> (o_rdata == 8'h00))
    else $error("update strobe reads back set");

  soft_reset_seq_a: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (soft_req && !soft_reg) |=> soft_reg ##1
      (!soft_reg && o_pll.ref_div == {RST_REF_HIGH, RST_REF_LOW} && o_pll.pump == RST_PUMP))
    else $error("soft reset sequence wrong");

  ref_default_a: assert property (
    @(posedge i_clock)
    $fell(i_rst) |-> (o_pll.ref_div == {RST_REF_HIGH, RST_REF_LOW}))
    else $error("divider default not one");

endmodule // ccr_regs

/* test/ccr_host_model.sv */
`timescale 1ns/10ps

module ccr_host_model
(
  input  wire logic              i_clock,
  input  wire logic [7:0]        i_rdata,
  input  wire logic              i_rvalid,
  output ccr_pkg::ccr_req_s      o_req
);
  import ccr_pkg::*;

  initial o_req = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle write request, then idle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clock);
    o_req <= '0;
  endtask

  // one-cycle read request, answer sampled in the cycle after it is taken
  task automatic rd(input logic [11:0] a, output logic v, output logic [7:0] d);
    @(posedge i_clock);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clock);
    o_req <= '0;
    #1;
    v = i_rvalid;
    d = i_rdata;
  endtask

  task automatic update();
    wr(ADDR_UPDATE, 8'h01);
  endtask
endmodule // ccr_host_model

/* test/tb.sv */
`timescale 1ns/10ps

module tb;
  import ccr_pkg::*;

  localparam logic [7:0] DEV_ID = 8'h3c;  // arbitrary value

  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  ccr_req_s    req;
  logic [7:0]  rdata;
  logic        rvalid;
  ccr_pll_s    pll;
  logic [15:0] version;
  logic        sdo_active;
  logic        lsb_first;
  logic        soft_reset;
  int          n_mismatch = 0;
  int          compares   = 0;

  always #20 i_clock = ~i_clock;

  ccr_regs #(.DEVICE_ID(DEV_ID)) dut
  (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_req       (req),
    .o_rdata     (rdata),
    .o_rvalid    (rvalid),
    .o_pll       (pll),
    .o_version   (version),
    .o_sdo_active(sdo_active),
    .o_lsb_first (lsb_first),
    .o_soft_reset(soft_reset)
  );

  ccr_host_model host
  (
    .i_clock (i_clock),
    .i_rdata (rdata),
    .i_rvalid(rvalid),
    .o_req   (req)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic       v;
    logic [7:0] d;
    host.rd(a, v, d);
    chk({15'h0000, v}, 16'h0001);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  task automatic chk_pll(input logic [7:0] pump, input logic [13:0] rdiv, input logic [5:0] pa);
    chk({8'h00, pll.pump}, {8'h00, pump});
    chk({2'h0, pll.ref_div}, {2'h0, rdiv});
    chk({10'h000, pll.presc_a}, {10'h000, pa});
  endtask

  task automatic chk_defaults();
    chk_pll(RST_PUMP, {RST_REF_HIGH, RST_REF_LOW}, RST_PRESC_A);
    chk(version, {RST_VER_HIGH, RST_VER_LOW});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_defaults();
    rd_chk(ADDR_READBACK, 8'h00);
    rd_chk(ADDR_DEV_ID, DEV_ID);
    rd_chk(ADDR_PORT_CFG, RST_PORT_CFG);
  endtask

  task automatic t_buffered();
    host.wr(ADDR_REF_LOW, 8'h05);
    host.wr(ADDR_REF_HIGH, 8'hff);
    host.wr(ADDR_PRESC_A, 8'hff);
    host.wr(ADDR_VER_LOW, 8'h34);
    host.wr(ADDR_VER_HIGH, 8'h12);
    chk_pll(RST_PUMP, 14'h0001, 6'h00);
    chk(version, 16'h0000);
    rd_chk(ADDR_REF_HIGH, 8'h3f);
    rd_chk(ADDR_PRESC_A, 8'h3f);
    host.update();
    #1;
    chk_pll(RST_PUMP, 14'h3f05, 6'h3f);
    chk(version, 16'h1234);
  endtask

  task automatic t_readback();
    host.wr(ADDR_READBACK, 8'hff);
    rd_chk(ADDR_READBACK, 8'h01);
    host.update();
    host.wr(ADDR_REF_LOW, 8'h09);
    rd_chk(ADDR_REF_LOW, 8'h05);
    rd_chk(ADDR_VER_HIGH, 8'h12);
    chk_pll(RST_PUMP, 14'h3f05, 6'h3f);
    host.wr(ADDR_READBACK, 8'h00);
    host.update();
    #1;
    chk_pll(RST_PUMP, 14'h3f09, 6'h3f);
    rd_chk(ADDR_REF_LOW, 8'h09);
  endtask

  task automatic t_ignore();
    logic [11:0] addrs [6] = '{12'h001, 12'h002, 12'h003, 12'h00a, 12'h100, 12'h0f0};
    foreach (addrs[i])
      host.wr(addrs[i], 8'hff);
    host.update();
    rd_chk(ADDR_DEV_ID, DEV_ID);
    rd_chk(12'h100, 8'h00);
    rd_chk(ADDR_UPDATE, 8'h00);
    chk_pll(RST_PUMP, 14'h3f09, 6'h3f);
    chk(version, 16'h1234);
    host.wr(ADDR_PORT_CFG, 8'h81);
    #1;
    chk({14'h0000, sdo_active, lsb_first}, 16'h0002);
    host.wr(ADDR_PORT_CFG, 8'h42);
    #1;
    chk({14'h0000, sdo_active, lsb_first}, 16'h0001);
  endtask

  task automatic t_soft();
    logic [7:0]  codes [2] = '{8'ha1, 8'h46};
    logic [15:0] cfgs [2]  = '{16'h0002, 16'h0001};
    foreach (codes[i])
    begin
      host.wr(ADDR_PUMP, 8'h11);
      host.update();
      host.wr(ADDR_PORT_CFG, codes[i]);
      #1;
      chk({15'h0000, soft_reset}, 16'h0001);
      chk({14'h0000, sdo_active, lsb_first}, cfgs[i]);
      @(posedge i_clock);
      #1;
      chk({15'h0000, soft_reset}, 16'h0000);
      chk_defaults();
      chk({14'h0000, sdo_active, lsb_first}, 16'h0000);
      rd_chk(ADDR_PORT_CFG, RST_PORT_CFG);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    #1;
    t_reset();
    t_buffered();
    t_readback();
    t_ignore();
    t_soft();
    test_done();
  end

  initial
  begin
    #(40 * 5000);
    n_mismatch++;
    test_done();
  end
endmodule // tb
